// ---- hdl/margin_regs.sv ----
// Margin register store: command, upper and lower words with write protect
`timescale 1ns/1ps
module margin_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic        write_protect,
  // Read port
  input  wire logic [1:0]  rd_sel,
  output logic      [15:0] rd_data,
  // Live values
  output logic      [15:0] margin_setting_reg,
  output logic      [15:0] margin_upper_reg,
  output logic      [15:0] margin_lower_reg
);
  // ---------------------------------------------------------------
  // Clamp helper
  // ---------------------------------------------------------------
  // Holds any write inside the +/-25 % span
  function automatic logic [15:0] clamp(input logic signed [15:0] v);
    if (v > pgmc_pkg::MARGIN_MAX) begin
      clamp = pgmc_pkg::MARGIN_MAX;
    end else if (v < pgmc_pkg::MARGIN_MIN) begin
      clamp = pgmc_pkg::MARGIN_MIN;
    end else begin
      clamp = v;
    end
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Writes dropped while protect is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      margin_setting_reg <= pgmc_pkg::MARGIN_RESET; // RQ18
      margin_upper_reg   <= pgmc_pkg::MARGIN_RESET;
      margin_lower_reg   <= pgmc_pkg::MARGIN_RESET;
    end else if (wr_en && !write_protect) begin // RQ5
      case (wr_sel)
        2'h0: margin_setting_reg <= clamp(wr_data); // RQ17
        2'h1: margin_upper_reg   <= clamp(wr_data);
        2'h2: margin_lower_reg   <= clamp(wr_data);
        default: ;
      endcase
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      case (rd_sel)
        2'h0:    rd_data <= margin_setting_reg;
        2'h1:    rd_data <= margin_upper_reg;
        2'h2:    rd_data <= margin_lower_reg;
        default: rd_data <= 16'h0000;
      endcase
    end
  end
endmodule

// ---- hdl/pgmc_pkg.sv ----
// Shared constants for the power-good and margin control shell
package pgmc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ        = 25_000_000;  // Control clock rate
  localparam int unsigned DELAY_BASE_US     = 200;         // Shortest deglitch delay
  localparam int unsigned DELAY_BASE_CYC    = (REF_CLK_HZ / 1_000_000) * DELAY_BASE_US;
  localparam int unsigned DROPOUT_CYCLES    = 16;          // Out-of-window switching cycles tolerated
  localparam int unsigned FIXED_SW_HZ       = 1_000_000;   // Internal fixed switching rate
  localparam int unsigned FIXED_HALF_CYC    = REF_CLK_HZ / FIXED_SW_HZ / 2;
  localparam int unsigned SLOW_REFRESH_HZ   = 1;           // Measurement refresh in standby
  localparam int unsigned SLOW_REFRESH_CYC  = REF_CLK_HZ / SLOW_REFRESH_HZ;
  localparam int unsigned FAST_REFRESH_HZ   = 25;          // Measurement refresh when running
  localparam int unsigned FAST_REFRESH_CYC  = REF_CLK_HZ / FAST_REFRESH_HZ;
  // ---------------------------------------------------------------
  // Margin format
  // ---------------------------------------------------------------
  localparam int unsigned MARGIN_W          = 16;          // Register width, 0.1 % per bit
  localparam logic signed [15:0] MARGIN_MAX = 16'sh00FA;   // +25.0 %
  localparam logic signed [15:0] MARGIN_MIN = -16'sh00FA;  // -25.0 %
  localparam logic [15:0] MARGIN_RESET      = 16'h0000;    // 0 % at power-up
  localparam logic [7:0]  WINDOW_DEFAULT    = 8'h64;       // +/-10.0 % in 0.1 % steps
  localparam int unsigned ADDR_LSB_W        = 3;           // Strap-derived address bits
  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MSRC_COMMAND = 2'b00,  // Pin floating
    MSRC_UPPER   = 2'b01,  // Pin high
    MSRC_LOWER   = 2'b10   // Pin low
  } margin_source_t;
  typedef enum logic [1:0] {
    OK_LOW  = 2'b00,  // Flag held low, waiting for window
    OK_WAIT = 2'b01,  // In window, deglitch running
    OK_HIGH = 2'b11   // Flag released
  } ok_state_t;
endpackage

// ---- hdl/power_good_margin_control.sv ----
// Power-good supervisor, margin source select, run states and strap decode
`timescale 1ns/1ps
//
// Contract
// [RQ1] Flag low at start-up and out of window
// [RQ2] Release after in-window longer than delay
// [RQ3] Drop after more than 16 out cycles
// [RQ4] Delay is 200us times 2^N, N 0-5,7
// [RQ5] Write protect blocks margin register writes
// [RQ6] Floating select uses margin command register
// [RQ7] High select ramps to upper register
// [RQ8] Low select ramps to lower register
// [RQ9] Master run low shuts everything off
// [RQ10] Standby off stops regulator, refresh 1Hz
// [RQ11] Clock out is switching clock inverted
// [RQ12] Mode pin picks DCM, FCM or sync
// [RQ13] Frequency pin tied high uses 1MHz
// [RQ14] Negative sense tied high means slave
// [RQ15] Address low bits come from strap
// [RQ16] Threshold pin high gives +/-10% window
// [RQ17] Margin limited to +/-25 percent
// [RQ18] Margin two's complement 0.1%/bit, zero reset
// [RQ19] Counters restart when comparator changes
module power_good_margin_control (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Run pins (comparator levels, asynchronous)
  input  wire logic        master_run_input,
  input  wire logic        standby_run_input,
  // Power-good supervision
  input  wire logic        window_in,
  input  wire logic [2:0]  ok_delay_select,
  input  wire logic        ok_window_limit_tied,
  input  wire logic [7:0]  ok_window_limit,
  output logic             output_ok_flag_oe,
  output logic      [7:0]  window_limit,
  // Margin select pin states (asynchronous)
  input  wire logic        margin_pin_high,
  input  wire logic        margin_pin_low,
  input  wire logic        write_protect,
  // Margin register access from the serial interface
  input  wire logic        margin_wr_en,
  input  wire logic [1:0]  margin_wr_sel,
  input  wire logic [15:0] margin_wr_data,
  input  wire logic [1:0]  margin_rd_sel,
  output logic      [15:0] margin_rd_data,
  output logic      [15:0] margin_target,
  output logic      [1:0]  margin_source,
  // Clocking and mode pins (asynchronous)
  input  wire logic        sw_clk_in,
  input  wire logic        mode_sync_in,
  input  wire logic        freq_set_tied,
  input  wire logic        neg_sense_tied,
  output logic             antiphase_clock_out,
  output logic             sw_clk,
  output logic             discontinuous_mode,
  output logic             sync_locked,
  output logic             slave_phase,
  // Address strap
  input  wire logic [2:0]  address_strap_input,
  output logic      [2:0]  addr_lsbs,
  // Enables
  output logic             regulator_en,
  output logic             measure_en,
  output logic             serial_en,
  output logic             refresh_tick
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NSYNC = 14;
  logic [NSYNC-1:0] sync_a;  // First stage, read only by second
  logic [NSYNC-1:0] sync_b;  // Usable synchronised levels
  logic [NSYNC-1:0] raw_in;  // Gathered pin levels

  assign raw_in = {master_run_input, standby_run_input, window_in, margin_pin_high,
                   margin_pin_low, write_protect, sw_clk_in, mode_sync_in,
                   freq_set_tied, neg_sense_tied, ok_window_limit_tied, address_strap_input};

  // Two flops on every pin level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic s_run, s_stby, s_win, s_mhi, s_mlo, s_wp, s_swin, s_mode, s_fset, s_neg, s_lim;
  logic [2:0] s_addr;
  assign {s_run, s_stby, s_win, s_mhi, s_mlo, s_wp, s_swin, s_mode,
          s_fset, s_neg, s_lim, s_addr} = sync_b;

  // ---------------------------------------------------------------
  // Run states
  // ---------------------------------------------------------------
  logic active;  // Whole device running
  assign active = s_run; // RQ9

  // Registered enables from run pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regulator_en <= 1'b0;
      measure_en   <= 1'b0;
      serial_en    <= 1'b0;
    end else begin
      regulator_en <= active && s_stby; // RQ10
      measure_en   <= active; // RQ9
      serial_en    <= active; // RQ9
    end
  end

  // Measurement refresh pacing, slowed in standby
  logic [24:0] refresh_cnt;  // Refresh period counter
  logic [24:0] refresh_top;  // Current period end
  assign refresh_top = s_stby ? 25'(pgmc_pkg::FAST_REFRESH_CYC - 1)
                              : 25'(pgmc_pkg::SLOW_REFRESH_CYC - 1); // RQ10

  always_ff @(posedge ref_clk) begin
    if (rst || !active) begin
      refresh_cnt  <= '0;
      refresh_tick <= 1'b0;
    end else if (refresh_cnt >= refresh_top) begin
      refresh_cnt  <= '0;
      refresh_tick <= 1'b1;
    end else begin
      refresh_cnt  <= refresh_cnt + 25'h0000001;
      refresh_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Switching clock: fixed, external or sync
  // ---------------------------------------------------------------
  logic [4:0] fix_cnt;   // Internal 1MHz divider
  logic       fix_clk;   // Internal fixed clock
  logic       mode_d;    // Previous mode level
  logic [7:0] quiet;     // Cycles since last mode edge
  logic       sw_d;      // Previous switching level

  // Divider for the fixed internal oscillator
  always_ff @(posedge ref_clk) begin
    if (rst || !active) begin
      fix_cnt <= '0;
      fix_clk <= 1'b0;
    end else if (fix_cnt == 5'(pgmc_pkg::FIXED_HALF_CYC - 1)) begin
      fix_cnt <= '0;
      fix_clk <= ~fix_clk; // RQ13
    end else begin
      fix_cnt <= fix_cnt + 5'h01;
    end
  end

  // Edge watch on the mode pin, a toggling pin means sync
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_d <= 1'b0;
      quiet  <= 8'hFF;
    end else begin
      mode_d <= s_mode;
      if (s_mode != mode_d) begin
        quiet <= 8'h00;
      end else if (quiet != 8'hFF) begin
        quiet <= quiet + 8'h01;
      end
    end
  end

  // Lock follows the external clock while it toggles; a static level picks the mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_locked        <= 1'b0;
      discontinuous_mode <= 1'b0;
      sw_clk             <= 1'b0;
      antiphase_clock_out <= 1'b1;
    end else begin
      sync_locked <= (quiet != 8'hFF); // RQ12
      if (quiet == 8'hFF) begin
        discontinuous_mode <= s_mode; // RQ12
      end
      if (!active) begin
        sw_clk <= 1'b0;
      end else if (quiet != 8'hFF) begin
        sw_clk <= s_mode; // RQ12
      end else if (s_fset) begin
        sw_clk <= fix_clk; // RQ13
      end else begin
        sw_clk <= s_swin;
      end
      antiphase_clock_out <= ~sw_clk_next(quiet, active, s_mode, s_fset, fix_clk, s_swin); // RQ11
    end
  end

  // Same selection as sw_clk, so the inverted copy lands in the same cycle
  function automatic logic sw_clk_next(input logic [7:0] q, input logic a, input logic m,
                                       input logic f, input logic fc, input logic s);
    if (!a) begin
      sw_clk_next = 1'b0;
    end else if (q != 8'hFF) begin
      sw_clk_next = m;
    end else if (f) begin
      sw_clk_next = fc;
    end else begin
      sw_clk_next = s;
    end
  endfunction

  // Rising switching edge marks one switching cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_d <= 1'b0;
    end else begin
      sw_d <= sw_clk;
    end
  end
  logic sw_edge;
  assign sw_edge = sw_clk && !sw_d;

  // ---------------------------------------------------------------
  // Straps followed every cycle after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_lsbs    <= '0;
      slave_phase  <= 1'b0;
      window_limit <= pgmc_pkg::WINDOW_DEFAULT;
    end else begin
      addr_lsbs    <= s_addr; // RQ15
      slave_phase  <= s_neg; // RQ14
      window_limit <= s_lim ? pgmc_pkg::WINDOW_DEFAULT : ok_window_limit; // RQ16
    end
  end

  // ---------------------------------------------------------------
  // Power-good supervisor
  // ---------------------------------------------------------------
  // Deglitch length: base times 2^N, code 6 maps to N = 7
  function automatic logic [31:0] delay_cycles(input logic [2:0] sel);
    logic [2:0] n;
    n = (sel == 3'h6 || sel == 3'h7) ? 3'h7 : sel;
    delay_cycles = 32'(pgmc_pkg::DELAY_BASE_CYC) << n; // RQ4
  endfunction

  pgmc_pkg::ok_state_t ok_state;  // Supervisor state
  logic [31:0] in_cnt;            // Continuous in-window cycles
  logic [4:0]  out_cnt;           // Continuous out-of-window switching cycles
  logic        win_d;             // Previous comparator level

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_d <= 1'b0;
    end else begin
      win_d <= s_win;
    end
  end

  // Counters restart on any comparator change
  always_ff @(posedge ref_clk) begin
    if (rst || !active || s_win != win_d) begin // RQ19
      in_cnt  <= '0;
      out_cnt <= '0;
    end else if (s_win) begin
      if (in_cnt != 32'hFFFFFFFF) begin
        in_cnt <= in_cnt + 32'h00000001;
      end
    end else if (sw_edge && out_cnt != 5'h1F) begin
      out_cnt <= out_cnt + 5'h01;
    end
  end

  // Flag state: hold low, deglitch, released
  always_ff @(posedge ref_clk) begin
    if (rst || !active) begin
      ok_state <= pgmc_pkg::OK_LOW; // RQ1
    end else begin
      case (ok_state)
        pgmc_pkg::OK_LOW:  if (s_win) ok_state <= pgmc_pkg::OK_WAIT;
        pgmc_pkg::OK_WAIT: begin
          if (!s_win) begin
            ok_state <= pgmc_pkg::OK_LOW; // RQ1
          end else if (in_cnt > delay_cycles(ok_delay_select)) begin
            ok_state <= pgmc_pkg::OK_HIGH; // RQ2
          end
        end
        pgmc_pkg::OK_HIGH: begin
          if (!s_win && out_cnt > 5'(pgmc_pkg::DROPOUT_CYCLES)) begin
            ok_state <= pgmc_pkg::OK_LOW; // RQ3
          end
        end
        default: ok_state <= pgmc_pkg::OK_LOW;
      endcase
    end
  end

  // Open drain pull-down enabled while not released
  assign output_ok_flag_oe = (ok_state != pgmc_pkg::OK_HIGH); // RQ1

  // ---------------------------------------------------------------
  // Margin registers and source selection
  // ---------------------------------------------------------------
  logic [15:0] m_cmd, m_up, m_lo;  // Live register values

  margin_regs u_regs (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .wr_en              (margin_wr_en && serial_en),
    .wr_sel             (margin_wr_sel),
    .wr_data            (margin_wr_data),
    .write_protect      (s_wp),
    .rd_sel             (margin_rd_sel),
    .rd_data            (margin_rd_data),
    .margin_setting_reg (m_cmd),
    .margin_upper_reg   (m_up),
    .margin_lower_reg   (m_lo)
  );

  // Pin high wins over pin low if both report at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      margin_source <= pgmc_pkg::MSRC_COMMAND;
      margin_target <= pgmc_pkg::MARGIN_RESET;
    end else if (s_mhi) begin
      margin_source <= pgmc_pkg::MSRC_UPPER;
      margin_target <= m_up; // RQ7
    end else if (s_mlo) begin
      margin_source <= pgmc_pkg::MSRC_LOWER;
      margin_target <= m_lo; // RQ8
    end else begin
      margin_source <= pgmc_pkg::MSRC_COMMAND;
      margin_target <= m_cmd; // RQ6
    end
  end
endmodule

// ---- tb/board_model.sv ----
// Board-side model: the resistor-programmed oscillator pin
`timescale 1ns/1ps
module board_model #(
  parameter int HALF_NS = 320  // Half period, 16 control cycles a period
) (
  // Oscillator pin
  output logic sw_clk_in
);
  // ---------------------------------------------------------------
  // Free-running oscillator, offset so no edge meets a control edge
  // ---------------------------------------------------------------
  initial begin
    sw_clk_in = 1'b0;
    #7;
    forever #HALF_NS sw_clk_in = ~sw_clk_in;
  end
endmodule

// ---- tb/pgmc_assertions.sv ----
// Port-level checks for the power-good and margin control shell
`timescale 1ns/1ps
module pgmc_assertions (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Pins
  input wire logic       master_run_input,
  input wire logic       standby_run_input,
  input wire logic       window_in,
  input wire logic       ok_window_limit_tied,
  input wire logic       margin_pin_high,
  input wire logic       margin_pin_low,
  input wire logic [2:0] address_strap_input,
  // Results
  input wire logic       output_ok_flag_oe,
  input wire logic [7:0] window_limit,
  input wire logic [1:0] margin_source,
  input wire logic       antiphase_clock_out,
  input wire logic       sw_clk,
  input wire logic [2:0] addr_lsbs,
  input wire logic       regulator_en,
  input wire logic       measure_en,
  input wire logic       serial_en,
  input wire logic       refresh_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Helper: uninterrupted in-window run, saturating
  // ---------------------------------------------------------------
  logic [15:0] in_run;  // Cycles since window last went out
  always_ff @(posedge ref_clk) begin
    if (rst || !window_in) begin
      in_run <= 16'h0000;
    end else if (in_run != 16'hFFFF) begin
      in_run <= in_run + 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Shortest delay bounds every release; synchronisers only add to it
  a_release_late: assert property ($fell(output_ok_flag_oe) |-> in_run > 16'h1388)
    else $error("flag released too early");
  // A drop while running needs the window to have been out
  a_drop_cause: assert property ($rose(output_ok_flag_oe) && !$past(rst) && master_run_input
    && $past(master_run_input, 4) |-> !$past(window_in, 3))
    else $error("flag dropped while in window");
  a_shut_all: assert property ((!master_run_input)[*4]
    |-> !regulator_en && !measure_en && !serial_en && output_ok_flag_oe)
    else $error("master run low left something on");
  a_standby_keep: assert property ((master_run_input && !standby_run_input)[*4]
    |-> !regulator_en && measure_en && serial_en)
    else $error("standby enables wrong");
  // Refresh ticks only while measuring, and never two in a row
  a_tick_pulse: assert property (refresh_tick |-> measure_en ##1 !refresh_tick)
    else $error("refresh tick not a single running pulse");
  a_src_upper: assert property ((margin_pin_high)[*4] |-> margin_source == pgmc_pkg::MSRC_UPPER)
    else $error("high pin not on upper source");
  a_src_lower: assert property ((margin_pin_low && !margin_pin_high)[*4]
    |-> margin_source == pgmc_pkg::MSRC_LOWER)
    else $error("low pin not on lower source");
  a_src_command: assert property ((!margin_pin_high && !margin_pin_low)[*4]
    |-> margin_source == pgmc_pkg::MSRC_COMMAND)
    else $error("floating pin not on command source");
  a_clock_anti: assert property (antiphase_clock_out == !sw_clk)
    else $error("clock out not inverted");
  // Strap outputs carry cleared synchroniser levels for two edges after reset
  a_addr_strap: assert property (($stable(address_strap_input) && !rst)[*4]
    |-> addr_lsbs == address_strap_input)
    else $error("address bits differ from strap");
  a_window_dflt: assert property ((ok_window_limit_tied && !rst)[*4]
    |-> window_limit == pgmc_pkg::WINDOW_DEFAULT)
    else $error("default window not applied");
endmodule
bind power_good_margin_control pgmc_assertions u_pgmc_assertions (
  .ref_clk, .rst, .master_run_input, .standby_run_input, .window_in, .ok_window_limit_tied,
  .margin_pin_high, .margin_pin_low, .address_strap_input, .output_ok_flag_oe, .window_limit,
  .margin_source, .antiphase_clock_out, .sw_clk, .addr_lsbs, .regulator_en, .measure_en, .serial_en,
  .refresh_tick
);

// ---- tb/tb_top.sv ----
// Self-checking bench for the power-good and margin control shell
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        ref_clk, rst, master_run_input, standby_run_input, window_in;
  logic        ok_window_limit_tied, margin_pin_high, margin_pin_low, write_protect;
  logic        margin_wr_en, sw_clk_in, mode_sync_in, freq_set_tied, neg_sense_tied;
  logic [2:0]  ok_delay_select, address_strap_input, addr_lsbs;
  logic [7:0]  ok_window_limit, window_limit;
  logic [1:0]  margin_wr_sel, margin_rd_sel, margin_source;
  logic [15:0] margin_wr_data, margin_rd_data, margin_target;
  logic        output_ok_flag_oe, antiphase_clock_out, sw_clk, discontinuous_mode;
  logic        sync_locked, slave_phase, regulator_en, measure_en, serial_en, sync_on;
  int          n_errors, n_compared, cycles, e;
  logic [15:0] ev [3];  // Expected stored words after clamping
  // ---------------------------------------------------------------
  // Design, board model and clock
  // ---------------------------------------------------------------
  power_good_margin_control u_power_good_margin_control (
    .ref_clk, .rst, .master_run_input, .standby_run_input, .window_in, .ok_delay_select,
    .ok_window_limit_tied, .ok_window_limit, .output_ok_flag_oe, .window_limit, .margin_pin_high,
    .margin_pin_low, .write_protect, .margin_wr_en, .margin_wr_sel, .margin_wr_data, .margin_rd_sel,
    .margin_rd_data, .margin_target, .margin_source, .sw_clk_in, .mode_sync_in, .freq_set_tied,
    .neg_sense_tied, .antiphase_clock_out, .sw_clk, .discontinuous_mode, .sync_locked, .slave_phase,
    .address_strap_input, .addr_lsbs, .regulator_en, .measure_en, .serial_en, .refresh_tick()
  );
  board_model u_board_model (.sw_clk_in);
  always #20 ref_clk = ~ref_clk;
  // External sync clock, ten control cycles a period
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (sync_on && cycles % 5 == 0) begin
      mode_sync_in <= ~mode_sync_in;
    end
    // Ceiling well above the roughly 41k cycles the tests need
    if (cycles == 60000) begin
      n_errors++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One write pulse; an idle edge follows so the strobe is never reassigned at once
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    margin_wr_en <= 1'b1;
    margin_wr_sel <= sel;
    margin_wr_data <= d;
    cyc(1);
    margin_wr_en <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
    margin_rd_sel <= sel;
    cyc(2);
    chk(margin_rd_data, exp, "read");
  endtask
  // Counts sw_clk rises over n cycles, checking clock out on each
  task automatic edges(input int n, output int k);
    logic p;
    k = 0;
    p = sw_clk;
    repeat (n) begin
      @(posedge ref_clk);
      if (sw_clk && !p) k++;
      p = sw_clk;
      chk(antiphase_clock_out, !sw_clk, "clock out");
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {ref_clk, window_in, margin_pin_high, margin_pin_low, write_protect, margin_wr_en} = '0;
    {mode_sync_in, neg_sense_tied, sync_on, n_errors, n_compared, cycles} = '0;
    {rst, master_run_input, standby_run_input, ok_window_limit_tied, freq_set_tied} = '1;
    ok_delay_select = 3'h0;
    address_strap_input = 3'h5;
    ok_window_limit = 8'h20;
    margin_wr_sel = 2'h0;
    margin_rd_sel = 2'h0;
    margin_wr_data = 16'h0000;
    ev = '{16'h0032, 16'h00FA, 16'hFF06};
    cyc(8);
    rst <= 1'b0;
    cyc(6);
    // Power-up state
    chk(output_ok_flag_oe, 1'b1, "flag at start");
    chk(window_limit, 8'h64, "default window");
    chk(addr_lsbs, 3'h5, "strap bits");
    for (int s = 0; s < 3; s++) rd(2'(s), 16'h0000);
    // Writes, with out-of-range words clamped to 25 percent
    wr(2'h0, 16'h0032);
    wr(2'h1, 16'h0100);
    wr(2'h2, 16'hFF00);
    for (int s = 0; s < 3; s++) rd(2'(s), ev[s]);
    // Protected writes are dropped
    write_protect <= 1'b1;
    // Protect pin crosses two synchroniser stages before it gates writes
    cyc(3);
    for (int s = 0; s < 3; s++) wr(2'(s), 16'h0001);
    for (int s = 0; s < 3; s++) rd(2'(s), ev[s]);
    write_protect <= 1'b0;
    // Margin source: floating, high, low
    for (int s = 0; s < 3; s++) begin
      margin_pin_high <= (s == 1);
      margin_pin_low <= (s == 2);
      cyc(5);
      chk(margin_target, ev[s], "margin target");
    end
    margin_pin_low <= 1'b0;
    // Flag release for three delay codes, then the drop-out filter
    for (int i = 0; i < 3; i++) begin
      ok_delay_select <= 3'(i);
      window_in <= 1'b1;
      // A short out-of-window gap restarts the deglitch count
      if (i == 0) begin
        cyc(3000);
        window_in <= 1'b0;
        cyc(4);
        window_in <= 1'b1;
      end
      cyc((pgmc_pkg::DELAY_BASE_CYC << i) - 2);
      chk(output_ok_flag_oe, 1'b1, "flag before delay");
      cyc(12);
      chk(output_ok_flag_oe, 1'b0, "flag after delay");
      window_in <= 1'b0;
      cyc(200);
      window_in <= 1'b1;
      cyc(10);
      window_in <= 1'b0;
      cyc(300);
      chk(output_ok_flag_oe, 1'b0, "flag within filter");
      cyc(200);
      chk(output_ok_flag_oe, 1'b1, "flag after filter");
    end
    // Clock sources: fixed 1MHz, oscillator pin, external sync
    edges(48, e);
    chk(16'(e), 16'h0002, "fixed clock rises");
    freq_set_tied <= 1'b0;
    cyc(10);
    edges(48, e);
    chk(16'(e), 16'h0003, "oscillator rises");
    sync_on <= 1'b1;
    cyc(40);
    chk(sync_locked, 1'b1, "sync lock");
    edges(50, e);
    chk(16'(e), 16'h0005, "sync rises");
    sync_on <= 1'b0;
    cyc(1);
    mode_sync_in <= 1'b1;
    cyc(300);
    chk(sync_locked, 1'b0, "sync lost");
    chk(discontinuous_mode, 1'b1, "light-load mode");
    mode_sync_in <= 1'b0;
    cyc(5);
    chk(discontinuous_mode, 1'b0, "continuous mode");
    // Run states
    standby_run_input <= 1'b0;
    cyc(5);
    chk({regulator_en, measure_en, serial_en}, 3'b011, "standby enables");
    standby_run_input <= 1'b1;
    master_run_input <= 1'b0;
    cyc(5);
    chk({regulator_en, measure_en, serial_en, output_ok_flag_oe}, 4'h1, "shutdown");
    master_run_input <= 1'b1;
    // Straps
    neg_sense_tied <= 1'b1;
    address_strap_input <= 3'h2;
    ok_window_limit_tied <= 1'b0;
    cyc(5);
    chk(slave_phase, 1'b1, "slave phase");
    chk(addr_lsbs, 3'h2, "strap bits");
    chk(window_limit, 8'h20, "pin window");
    conclude();
  end
endmodule
